// File: boot_host_ctrl.sv
/*
  host-side controller: drives device reset, waits for the boot download (stall mode
  instead stretches the first access until busy releases), then runs single read/write cycles with chip select and strobes.
  assumes a 50 MHz CORE_CLK, a synchronous active-low RESET_N and a
  device busy pin that is asynchronous to CORE_CLK.
*/
`include "boot_host_regs.svh"
module boot_host_ctrl (
  input  wire logic                          CORE_CLK,
  input  wire logic                          RESET_N,
  input  wire logic                          START_RESET,
  input  wire boot_host_pkg::first_mode_type MODE,
  input  wire logic                          MUX_IF,
  input  wire logic                          REQ,
  input  wire logic                          REQ_WRITE,
  input  wire logic [12:0]                   REQ_ADDR,
  input  wire logic [15:0]                   REQ_WDATA,
  input  wire logic                          BUSY_N,
  input  wire logic [15:0]                   D_IN,
  output logic                               HW_RESET_IN_N,
  output logic                               ADDRESS_VALID_STROBE_N,
  output logic                               CE_N,
  output logic                               OE_N,
  output logic                               WE_N,
  output logic [12:0]                        ADDR,
  output logic [15:0]                        D_OUT,
  output logic                               D_OE_N,
  output logic                               READY,
  output logic                               DONE,
  output logic [15:0]                        RDATA,
  output logic                               BOOT_TIMEOUT
);
  import boot_host_pkg::*;

  localparam logic [`CNT_W-1:0] RST_CYC  = `CNT_W'(`RST_PULSE_CYC);
  localparam logic [`CNT_W-1:0] AVD_CYC  = `CNT_W'(`AVD_HOLD_CYC);
  localparam logic [`CNT_W-1:0] BOOT_CYC = `CNT_W'(`BOOT_BUSY_CYC);
  localparam logic [`CNT_W-1:0] WE_CYC   = `CNT_W'(`WE_WIDTH_CYC);
  localparam logic [`CNT_W-1:0] RD_CYC   = `CNT_W'(`RD_ACC_CYC);
  localparam logic [`CNT_W-1:0] REC_CYC  = `CNT_W'(`REC_CYC);

  seq_state_type     state_ff;
  seq_state_type     nxt_state;
  logic [`CNT_W-1:0] cnt_ff;
  logic [`CNT_W-1:0] nxt_cnt;
  logic              first_ff;
  logic              wr_ff;
  logic              busy_n_s;
  logic              rst_n_ff;
  logic              avd_n_ff;
  logic              ce_n_ff;
  logic              oe_n_ff;
  logic              we_n_ff;
  logic              doe_n_ff;
  logic [12:0]       addr_ff;
  logic [15:0]       dout_ff;
  logic [15:0]       rdata_ff;
  logic              ready_ff;
  logic              done_ff;
  logic              tmo_ff;

  sync3 u_busy_sync (
    .clk      (CORE_CLK),
    .reset_n  (RESET_N),
    .async_in (BUSY_N),
    .init_val (1'b1),
    .sync_out (busy_n_s)
  );

  wire cnt_zero   = (cnt_ff == '0);
  wire cnt_dec_ok = !cnt_zero;
  // first access may only be stretched on busy in stall mode
  wire stall_busy = first_ff && (MODE == WAIT_STALL) && !busy_n_s;
  wire acc_end    = cnt_zero && !stall_busy;
  wire boot_ok    = (MODE == WAIT_TIMER) ? cnt_zero :
                    (MODE == WAIT_POLL)  ? busy_n_s : 1'b1;
  wire take_req   = (state_ff == ST_IDLE) && REQ;
  wire nxt_wr     = take_req ? REQ_WRITE : wr_ff;
  // access length follows the request being taken, not the last one
  wire [`CNT_W-1:0] acc_cyc = nxt_wr ? WE_CYC : RD_CYC;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_dec_ok ? cnt_ff - 1'b1 : cnt_ff;
    case (state_ff)
      ST_RESET: begin
        // hold reset low for the minimum pulse width
        if (cnt_zero) begin
          nxt_state = ST_AVD_HOLD;
          nxt_cnt   = AVD_CYC;
        end
      end
      ST_AVD_HOLD: begin
        // poll mode sits out the hold so a late busy fall is synchronised
        if (cnt_zero || (!MUX_IF && (MODE != WAIT_POLL))) begin
          nxt_state = ST_BOOT_WAIT;
          nxt_cnt   = BOOT_CYC;
        end
      end
      ST_BOOT_WAIT: begin
        // stall mode leaves at once, so a first access may be issued while the device still downloads boot code
        if (boot_ok) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (REQ) begin
          nxt_state = ST_ACCESS;
          nxt_cnt   = acc_cyc;
        end
      end
      ST_ACCESS: begin
        if (acc_end) begin
          nxt_state = ST_RECOVER;
          nxt_cnt   = REC_CYC;
        end
      end
      ST_RECOVER: begin
        if (cnt_zero) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_RESET;
        nxt_cnt   = RST_CYC;
      end
    endcase
    if (START_RESET) begin
      nxt_state = ST_RESET;
      nxt_cnt   = RST_CYC;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      state_ff <= ST_RESET;
      cnt_ff   <= RST_CYC;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // both strobes move together, so write start and end are one edge
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      rst_n_ff <= 1'b0;
      avd_n_ff <= 1'b0;
      ce_n_ff  <= 1'b1;
      oe_n_ff  <= 1'b1;
      we_n_ff  <= 1'b1;
      doe_n_ff <= 1'b1;
      addr_ff  <= 13'h0000;
      dout_ff  <= 16'h0000;
      rdata_ff <= 16'h0000;
      wr_ff    <= 1'b0;
      first_ff <= 1'b1;
      ready_ff <= 1'b0;
      done_ff  <= 1'b0;
      tmo_ff   <= 1'b0;
    end else begin
      rst_n_ff <= (nxt_state != ST_RESET);
      avd_n_ff <= (nxt_state != ST_RESET) && (nxt_state != ST_AVD_HOLD);
      ready_ff <= (nxt_state == ST_IDLE);
      done_ff  <= 1'b0;
      if (take_req) begin
        wr_ff   <= REQ_WRITE;
        addr_ff <= REQ_ADDR;
        dout_ff <= REQ_WDATA;
      end
      ce_n_ff  <= (nxt_state != ST_ACCESS);
      oe_n_ff  <= !((nxt_state == ST_ACCESS) && !nxt_wr);
      we_n_ff  <= !((nxt_state == ST_ACCESS) && nxt_wr);
      doe_n_ff <= !((nxt_state == ST_ACCESS) && nxt_wr);
      if ((state_ff == ST_ACCESS) && acc_end) begin
        done_ff  <= 1'b1;
        first_ff <= 1'b0;
        if (!wr_ff) begin
          rdata_ff <= D_IN;
        end
      end
      if (state_ff == ST_RESET) begin
        first_ff <= 1'b1;
        tmo_ff   <= 1'b0;
      end
      if ((state_ff == ST_BOOT_WAIT) && cnt_zero && !busy_n_s) begin
        tmo_ff <= 1'b1;
      end
    end
  end

  assign HW_RESET_IN_N          = rst_n_ff;
  assign ADDRESS_VALID_STROBE_N = avd_n_ff;
  assign CE_N                   = ce_n_ff;
  assign OE_N                   = oe_n_ff;
  assign WE_N                   = we_n_ff;
  assign ADDR                   = addr_ff;
  assign D_OUT                  = dout_ff;
  assign D_OE_N                 = doe_n_ff;
  assign READY                  = ready_ff;
  assign DONE                   = done_ff;
  assign RDATA                  = rdata_ff;
  assign BOOT_TIMEOUT           = tmo_ff;

  sequence s_reset_low;
    !HW_RESET_IN_N [*2];
  endsequence

  AST_RESET_WIDTH: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    $fell(HW_RESET_IN_N) |-> s_reset_low)
    else $error("reset pulse shorter than minimum");

  AST_AVD_HOLD: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    ($rose(HW_RESET_IN_N) && MUX_IF && !START_RESET) |->
      !ADDRESS_VALID_STROBE_N [*4])
    else $error("address strobe released too early");

  AST_NO_ACCESS_IN_RESET: assert property (@(posedge CORE_CLK)
    disable iff (!RESET_N)
    !HW_RESET_IN_N |-> CE_N)
    else $error("access during device reset");

  AST_POLL_GATE: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (state_ff == ST_BOOT_WAIT && MODE == WAIT_POLL && !busy_n_s
     && !START_RESET) |=> state_ff != ST_IDLE)
    else $error("poll mode left boot wait while busy");

  AST_STALL_HOLD: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (state_ff == ST_ACCESS && stall_busy && !START_RESET) |=> !CE_N)
    else $error("select dropped before busy release");

  AST_STROBE_PAIR: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (!WE_N || !OE_N) |-> !CE_N)
    else $error("strobe without chip select");

  AST_WRITE_END: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    $rose(CE_N) && !$past(WE_N) |-> WE_N)
    else $error("write strobe outlived chip select");

  AST_TIMER_WAIT: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (state_ff == ST_BOOT_WAIT && MODE == WAIT_TIMER && !cnt_zero
     && !START_RESET) |=> state_ff == ST_BOOT_WAIT)
    else $error("timer wait cut short");
endmodule

// File: boot_host_pkg.sv
/*
  types of the host-side sequencer.
  assumes nothing beyond a SystemVerilog compiler.
*/
package boot_host_pkg;
  typedef enum logic [1:0] {
    WAIT_TIMER,
    WAIT_POLL,
    WAIT_STALL
  } first_mode_type;

  typedef enum {
    ST_RESET,
    ST_AVD_HOLD,
    ST_BOOT_WAIT,
    ST_IDLE,
    ST_ACCESS,
    ST_RECOVER
  } seq_state_type;
endpackage

// File: boot_host_regs.svh
/*
  timing constants for the host-side reset and first-access sequencer.
  assumes a 50 MHz core clock (20 ns period).
*/
`ifndef BOOT_HOST_REGS_SVH
`define BOOT_HOST_REGS_SVH

`define CLK_PERIOD_NS        20
`define RST_PULSE_NS         30
`define RST_PULSE_CYC        ((`RST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define AVD_HOLD_NS          70
`define AVD_HOLD_CYC         ((`AVD_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUSY_MAX_US          1300
`define ERASE_EXTRA_US       500
`define BOOT_BUSY_CYC        ((`BUSY_MAX_US + `ERASE_EXTRA_US) * 1000 / `CLK_PERIOD_NS)
`define WE_WIDTH_NS          47
`define WE_WIDTH_CYC         ((`WE_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REC_NS               20
`define REC_CYC              ((`REC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_ACC_NS            103
`define RD_ACC_CYC           ((`RD_ACC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W                17

`endif

// File: flash_boot_dev.sv
/*
  behavioural flash disk device: reset, boot download busy, 8k x 16 words.
  assumes the host drives reset and strobes; the model has no clock.
*/
module flash_boot_dev #(
  parameter int BOOT_BUSY_NS = 6000,
  parameter int RD_NS        = 100,
  parameter int IRQ_NS       = 500
) (
  input  wire logic        hw_reset_in_n,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [12:0] addr,
  input  wire logic [15:0] d_out,
  input  wire logic        d_oe_n,
  output logic             busy_n,
  output logic [15:0]      d_in,
  output logic             irq_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [8192];
  logic [15:0] junk;
  logic [15:0] w_data;
  logic [12:0] w_addr;
  logic [15:0] rd_slow;
  wire         wr_act = !ce_n && !we_n;
  wire         rd_act = !ce_n && !oe_n;
  initial begin
    busy_n = 1'b0;
    irq_n  = 1'b1;
    junk   = 16'hA5A5;
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  always @(negedge hw_reset_in_n) busy_n = 1'b0;
  always @(posedge hw_reset_in_n) begin
    #(BOOT_BUSY_NS);
    if (hw_reset_in_n === 1'b1) busy_n = 1'b1;
  end
  // edge-mode interrupt pulse when the boot download ends
  always @(posedge busy_n) begin
    irq_n = 1'b0;
    #(IRQ_NS);
    irq_n = 1'b1;
  end
  always @(wr_act or d_out or addr or d_oe_n) begin
    if (wr_act && !d_oe_n) begin
      w_addr = addr;
      w_data = d_out;
    end
  end
  // write lands at the earlier negation; dropped during download
  always @(negedge wr_act) begin
    if (busy_n) mem[w_addr] = w_data;
  end
  always @(posedge rd_act) junk = ~junk ^ {3'h0, addr};
  assign #(RD_NS) rd_slow = rd_act ? mem[addr] : junk;
  assign d_in = busy_n ? rd_slow : junk;
endmodule

// File: sync3.sv
/*
  three-stage synchroniser with agreement of the last two stages.
  assumes the input is asynchronous to clk.
*/
module sync3 (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic async_in,
  input  wire logic init_val,
  output logic      sync_out
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic out_ff;
  wire  agree = (s2_ff == s3_ff);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s1_ff  <= init_val;
      s2_ff  <= init_val;
      s3_ff  <= init_val;
      out_ff <= init_val;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (agree) begin
        out_ff <= s3_ff;
      end
    end
  end

  assign sync_out = out_ff;
endmodule

// File: tb.sv
/*
  self-checking bench: host sequencer against the device model.
  assumes boot_host_pkg, boot_host_ctrl and flash_boot_dev are compiled.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import boot_host_pkg::*;
  localparam int BUSY_NS = 6000;
  logic           core_clk    = 1'b0;
  logic           reset_n     = 1'b0;
  logic           start_reset = 1'b0;
  first_mode_type mode        = WAIT_POLL;
  logic           mux_if      = 1'b1;
  logic           req         = 1'b0;
  logic           req_write   = 1'b0;
  logic [12:0]    req_addr    = 13'h0000;
  logic [15:0]    req_wdata   = 16'h0000;
  logic [15:0]    lfsr_ff     = 16'h005F;
  logic [12:0]    addr;
  logic [15:0]    d_in, d_out, rdata;
  logic           hw_rst_n, avd_n, ce_n, oe_n, we_n, d_oe_n;
  logic           ready, done, boot_to, busy_n, irq_n;
  int             bad_count, samples_checked, cyc, n, i;
  realtime        t_low, t_rel, t_irq;
  int             ref_mem [int];

  boot_host_ctrl u_dut (
    .CORE_CLK(core_clk), .RESET_N(reset_n), .START_RESET(start_reset),
    .MODE(mode), .MUX_IF(mux_if), .REQ(req), .REQ_WRITE(req_write),
    .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .BUSY_N(busy_n),
    .D_IN(d_in), .HW_RESET_IN_N(hw_rst_n), .ADDRESS_VALID_STROBE_N(avd_n),
    .CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n), .ADDR(addr), .D_OUT(d_out),
    .D_OE_N(d_oe_n), .READY(ready), .DONE(done), .RDATA(rdata),
    .BOOT_TIMEOUT(boot_to)
  );
  flash_boot_dev #(.BOOT_BUSY_NS(BUSY_NS), .RD_NS(100)) u_dev (
    .hw_reset_in_n(hw_rst_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .addr(addr), .d_out(d_out), .d_oe_n(d_oe_n), .busy_n(busy_n),
    .d_in(d_in), .irq_n(irq_n)
  );

  initial begin
    forever #10 core_clk = ~core_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [15:0] nxt_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] exp_rd(input int a);
    return ref_mem.exists(a) ? 16'(ref_mem[a]) : 16'h0000;
  endfunction
  task automatic wait_ready(input int lim);
    n = 0;
    while (ready !== 1'b1 && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    check({15'h0000, ready}, 16'h0001);
  endtask
  task automatic access(input logic wr, input logic [12:0] a,
                        input logic [15:0] d);
    wait_ready(5000);
    req = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    @(negedge core_clk);
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 5000) begin
      @(negedge core_clk);
      n++;
    end
    check({15'h0000, done}, 16'h0001);
    if (wr) ref_mem[a] = d;
    else check(rdata, exp_rd(a));
  endtask
  task automatic pulse_reset(input first_mode_type m);
    mode = m;
    start_reset = 1'b1;
    @(negedge core_clk);
    start_reset = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask

  always @(hw_rst_n) begin
    if (hw_rst_n === 1'b0) t_low = $realtime;
    if (hw_rst_n === 1'b1) begin
      check({15'h0000, $realtime - t_low >= 30.0}, 16'h0001);
      t_rel = $realtime;
    end
  end
  always @(posedge avd_n) begin
    if (mux_if)
      check({15'h0000, $realtime - t_rel >= 70.0}, 16'h0001);
  end
  always @(irq_n) begin
    if (irq_n === 1'b0) t_irq = $realtime;
    if (irq_n === 1'b1 && t_irq > 0.0) begin
      check({15'h0000, $realtime - t_irq >= 300.0}, 16'h0001);
      check({15'h0000, $realtime - t_irq <= 800.0}, 16'h0001);
    end
  end
  always @(posedge busy_n) begin
    if (mode == WAIT_STALL) check({15'h0000, ce_n}, 16'h0000);
  end
  // no select while busy, except in stall mode, where select is checked held low at busy release instead
  always @(negedge core_clk) begin
    if (busy_n === 1'b0 && mode != WAIT_STALL)
      check({15'h0000, ce_n}, 16'h0001);
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 98000) begin
      bad_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (16) @(negedge core_clk);
    check({15'h0000, hw_rst_n | avd_n}, 16'h0000);
    reset_n = 1'b1;
    wait_ready(5000);
    check({15'h0000, busy_n}, 16'h0001);
    check(16'(n >= BUSY_NS / 20), 16'h0001);
    for (i = 0; i < 16; i++) begin
      lfsr_ff = nxt_rand(lfsr_ff);
      access(lfsr_ff[15], {10'h000, lfsr_ff[2:0]}, nxt_rand(lfsr_ff));
    end
    mux_if = 1'b0;
    pulse_reset(WAIT_STALL);
    wait_ready(200);
    check({15'h0000, busy_n}, 16'h0000);
    access(1'b0, 13'h0003, 16'h0000);
    check({15'h0000, busy_n}, 16'h0001);
    access(1'b1, 13'h0005, 16'h1234);
    access(1'b0, 13'h0005, 16'h0000);
    pulse_reset(WAIT_TIMER);
    wait_ready(95000);
    check(16'(n >= (1300 + 500) * 1000 / 20 - 3), 16'h0001);
    check({15'h0000, boot_to}, 16'h0000);
    access(1'b0, 13'h0005, 16'h0000);
    give_verdict();
  end
endmodule
